// >>> rng_consts.svh
// Purpose: offsets, field positions, reset values and timing counts of the random source
// Assumes: 20 MHz system clock
// Notes:   included by bare name; definitions only
`ifndef RNG_CONSTS_SVH
`define RNG_CONSTS_SVH

// ---------------------------------------------------------------
// register offsets within the decode window
// ---------------------------------------------------------------
`define RNG_CFG_OFFSET   12'h000
`define RNG_STAT_OFFSET  12'h004
`define RNG_VAL_OFFSET   12'h008

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define RNG_GEN_OFF_BIT  2
`define RNG_READY_BIT    0
`define RNG_WORD_WIDTH   16
`define RNG_GEN_OFF_RST  1'h0
`define RNG_READY_RST    1'h0
`define RNG_VALUE_RST    16'h0000
`define RNG_RDATA_RST    32'h0000_0000

// ---------------------------------------------------------------
// bus encodings
// ---------------------------------------------------------------
`define AHB_SIZE_WORD    3'h2
`define AHB_DECODE_BITS  12

// ---------------------------------------------------------------
// timing: least sample period, rounded up to whole clocks
// ---------------------------------------------------------------
`define RNG_SAMPLE_PERIOD_NS 1250
`define RNG_CLK_PERIOD_NS    50
`define RNG_SAMPLE_CYCLES \
  ((`RNG_SAMPLE_PERIOD_NS + `RNG_CLK_PERIOD_NS - 1) / `RNG_CLK_PERIOD_NS)

`endif

// >>> rng_types_pkg.sv
// Purpose: types shared by the random source files
// Assumes: nothing
// Notes:   constants live in rng_consts.svh
package rng_types_pkg;

  // data-phase state of the bus slave
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_OK,
    PH_WAIT,
    PH_ERR1,
    PH_ERR2
  } phase_t;

endpackage

// >>> sample_link_if.sv
// Purpose: carries run control, noise and finished samples between register side and sampler
// Assumes: single clock domain
// Notes:   word is valid in the cycle strobe is high
`timescale 1ns/1ps
interface sample_link_if #(
  parameter int WIDTH = 16
);
  logic             enable;
  logic             noiseBit;
  logic             strobe;
  logic [WIDTH-1:0] word;

  modport producer (input enable, input noiseBit, output strobe, output word);
  modport consumer (output enable, output noiseBit, input strobe, input word);
endinterface

// >>> noise_sampler.sv
// Purpose: gathers noise bits into words at no more than one per sample period
// Assumes: noise bit is synchronous to clk
// Notes:   count and strobe held cleared while not enabled, shift register and word kept, which stands in for the gated clock
`timescale 1ns/1ps
`include "rng_consts.svh"
module noise_sampler
  import rng_types_pkg::*;
#(
  parameter int WIDTH  = `RNG_WORD_WIDTH,
  parameter int PERIOD = `RNG_SAMPLE_CYCLES
) (
  // clock and reset
  input  logic              clk,
  input  logic              rst_n,
  // link to the register side
  sample_link_if.producer   link
);

  localparam int CW = $clog2(PERIOD + 1);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

  generate
    if (PERIOD < 1 || WIDTH < 2) begin : gen_bad_param
      $error("noise_sampler: PERIOD must be at least 1 and WIDTH at least 2");
    end
  endgenerate

  logic [CW-1:0]    count;
  logic [WIDTH-1:0] shift;
  logic             periodDone;

  assign periodDone = (count == LAST);

  // ---------------------------------------------------------------
  // shift register and period counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count       <= '0;
      shift       <= '0;
      link.strobe <= 1'b0;
      link.word   <= '0;
    end else if (!link.enable) begin
      count       <= '0;
      link.strobe <= 1'b0;
    end else begin
      shift       <= {shift[WIDTH-2:0], link.noiseBit};
      count       <= periodDone ? '0 : count + CW'(1);
      link.strobe <= periodDone;
      if (periodDone) begin
        link.word <= shift;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [CW-1:0] gap;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap <= LAST;
    end else if (link.strobe) begin
      gap <= '0;
    end else if (gap != LAST) begin
      gap <= gap + CW'(1);
    end
  end

  AST_SAMPLE_SPACING: assert property (@(posedge clk) disable iff (!rst_n)
    link.strobe |-> gap == LAST)
    else $error("samples closer than the least sample period");

  AST_OFF_NO_SAMPLE: assert property (@(posedge clk) disable iff (!rst_n)
    !link.enable |=> !link.strobe)
    else $error("sample produced while generator is off");

endmodule

// >>> random_number_source.sv
// Purpose: register-mapped random number source on an AHB-lite slave port
// Assumes: 20 MHz clk, AHB-lite master, noise arrives as one bit per clock
// Notes:   a value read with no sample stalls the bus until one exists
`timescale 1ns/1ps
`include "rng_consts.svh"
module random_number_source
  import rng_types_pkg::*;
#(
  parameter int WIDTH  = `RNG_WORD_WIDTH,
  parameter int PERIOD = `RNG_SAMPLE_CYCLES
) (
  // clock and reset
  input  logic        clk,
  input  logic        rst_n,
  // AHB-lite slave
  input  logic        HSEL,
  input  logic [31:0] HADDR,
  input  logic [1:0]  HTRANS,
  input  logic        HWRITE,
  input  logic [2:0]  HSIZE,
  input  logic [31:0] HWDATA,
  input  logic        HREADY,
  output logic        HREADYOUT,
  output logic        HRESP,
  output logic [31:0] HRDATA,
  // noise source
  input  logic        noiseBit,
  output logic        noiseOscOn
);

  generate
    if (WIDTH != `RNG_WORD_WIDTH) begin : gen_bad_width
      $error("random_number_source: WIDTH must equal the 16-bit value field");
    end
  endgenerate

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  phase_t           phase;
  phase_t           next_phase;
  logic             genOff;
  logic             ready;
  logic             next_ready;
  logic [WIDTH-1:0] randomValue;
  logic             wrCfgPending;

  sample_link_if #(.WIDTH(WIDTH)) link ();

  noise_sampler #(
    .WIDTH  (WIDTH),
    .PERIOD (PERIOD)
  ) u_sampler (
    .clk   (clk),
    .rst_n (rst_n),
    .link  (link)
  );

  // ---------------------------------------------------------------
  // generator control
  // ---------------------------------------------------------------
  assign link.enable   = !genOff;
  assign link.noiseBit = noiseBit;
  assign noiseOscOn    = !genOff;

  // ---------------------------------------------------------------
  // address phase decode
  // ---------------------------------------------------------------
  logic [`AHB_DECODE_BITS-1:0] offset;
  logic                        accept;
  logic                        isCfg;
  logic                        isStat;
  logic                        isVal;
  logic                        mapped;
  logic                        badAccess;
  logic                        valRead;
  logic                        goodRead;
  logic                        takeValue;
  logic [31:0]                 regRead;

  assign offset    = HADDR[`AHB_DECODE_BITS-1:0];
  assign accept    = HSEL && HREADY && HTRANS[1];
  assign isCfg     = (offset == `RNG_CFG_OFFSET);
  assign isStat    = (offset == `RNG_STAT_OFFSET);
  assign isVal     = (offset == `RNG_VAL_OFFSET);
  assign mapped    = isCfg || isStat || isVal;
  assign badAccess = (HSIZE != `AHB_SIZE_WORD) || !mapped;
  assign valRead   = accept && !badAccess && !HWRITE && isVal;
  assign goodRead  = accept && !badAccess && !HWRITE;

  // read value is taken at acceptance if ready, else when ready arrives
  assign takeValue = (valRead && ready) || (phase == PH_WAIT && ready);

  // reserved bits read as zero
  assign regRead = isCfg  ? (32'(genOff) << `RNG_GEN_OFF_BIT) :
                   isStat ? (32'(ready) << `RNG_READY_BIT) :
                   32'h0000_0000;

  // ---------------------------------------------------------------
  // data phase sequencing
  // ---------------------------------------------------------------
  always_comb begin
    next_phase = PH_IDLE;
    unique case (phase)
      PH_WAIT: begin
        next_phase = ready ? PH_OK : PH_WAIT;
      end
      PH_ERR1: begin
        next_phase = PH_ERR2;
      end
      PH_IDLE, PH_OK, PH_ERR2: begin
        if (accept) begin
          if (badAccess) begin
            next_phase = PH_ERR1;
          end else if (valRead && !ready) begin
            next_phase = PH_WAIT;
          end else begin
            next_phase = PH_OK;
          end
        end
      end
    endcase
  end

  assign HREADYOUT = !(phase == PH_WAIT || phase == PH_ERR1);
  assign HRESP     = (phase == PH_ERR1 || phase == PH_ERR2);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase        <= PH_IDLE;
      wrCfgPending <= 1'b0;
    end else begin
      phase        <= next_phase;
      wrCfgPending <= accept && !badAccess && HWRITE && isCfg;
    end
  end

  // ---------------------------------------------------------------
  // configuration register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      genOff <= `RNG_GEN_OFF_RST;
    end else if (wrCfgPending) begin
      genOff <= HWDATA[`RNG_GEN_OFF_BIT];
    end
  end

  // ---------------------------------------------------------------
  // sample holding and ready flag
  // ---------------------------------------------------------------
  // a new sample wins over a read clearing the flag in the same cycle
  assign next_ready = genOff         ? 1'b0 :
                      link.strobe    ? 1'b1 :
                      takeValue      ? 1'b0 :
                      ready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready       <= `RNG_READY_RST;
      randomValue <= `RNG_VALUE_RST;
    end else begin
      ready <= next_ready;
      if (link.strobe) begin
        randomValue <= link.word;
      end
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      HRDATA <= `RNG_RDATA_RST;
    end else if (takeValue) begin
      HRDATA <= {16'h0000, randomValue};
    end else if (goodRead) begin
      HRDATA <= regRead;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_NARROW_ERROR: assert property (@(posedge clk) disable iff (!rst_n)
    (accept && HSIZE != `AHB_SIZE_WORD)
      |=> (HRESP && !HREADYOUT) ##1 (HRESP && HREADYOUT))
    else $error("narrow transfer not answered with a two-cycle error");

  AST_WORD_OKAY: assert property (@(posedge clk) disable iff (!rst_n)
    (accept && HSIZE == `AHB_SIZE_WORD && (isCfg || isStat)) |=> (!HRESP && HREADYOUT))
    else $error("word access to config or status not answered okay");

  AST_STALL_WHILE_EMPTY: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == PH_WAIT && !ready) |-> !HREADYOUT)
    else $error("value read completed without a sample");

  AST_FRESH_ON_WAIT: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == PH_WAIT && ready)
      |=> (HREADYOUT && !HRESP && HRDATA[15:0] == $past(randomValue)))
    else $error("stalled read did not return the new sample");

  AST_READ_CLEARS: assert property (@(posedge clk) disable iff (!rst_n)
    (valRead && ready && !link.strobe) |=> (!ready && HRDATA[15:0] == $past(randomValue)))
    else $error("completed value read did not consume the sample");

  AST_SAMPLE_SETS_READY: assert property (@(posedge clk) disable iff (!rst_n)
    (link.strobe && !genOff) |=> (ready && randomValue == $past(link.word)))
    else $error("new sample not latched with ready set");

  AST_OFF_NOT_READY: assert property (@(posedge clk) disable iff (!rst_n)
    (genOff && $past(genOff)) |-> !ready)
    else $error("ready flag high while generator is off");

  AST_STATUS_SHOWS_READY: assert property (@(posedge clk) disable iff (!rst_n)
    (goodRead && isStat) |=> (HRDATA == (32'($past(ready)) << `RNG_READY_BIT)))
    else $error("status read does not show the ready flag");

  AST_UPPER_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(takeValue)) |-> (HRDATA[31:16] == 16'h0000))
    else $error("reserved upper bits of the value read non-zero");

  AST_OFF_OSC_DOWN: assert property (@(posedge clk) disable iff (!rst_n)
    genOff |-> (!noiseOscOn && !link.enable))
    else $error("oscillators running while generator is off");

endmodule

// >>> ahb_host_model.sv
// Purpose: AHB-lite host that issues single transfers to the random source
// Assumes: HREADY is looped back from HREADYOUT
// Notes:   one transfer at a time; signals change 1 ns after the edge
`timescale 1ns/1ps
module ahb_host_model (
  // clock
  input  logic        clk,
  // bus request
  output logic        HSEL,
  output logic [31:0] HADDR,
  output logic [1:0]  HTRANS,
  output logic        HWRITE,
  output logic [2:0]  HSIZE,
  output logic [31:0] HWDATA,
  // bus answer
  input  logic        HREADYOUT,
  input  logic        HRESP,
  input  logic [31:0] HRDATA
);
  initial begin
    HSEL = 1'h0;
    HADDR = 32'h0;
    HTRANS = 2'h0;
    HWRITE = 1'h0;
    HSIZE = 3'h2;
    HWDATA = 32'h0;
  end

  // address phase, then hold the data phase until ready is seen high
  task automatic xfer(input logic [31:0] a, input logic w, input logic [2:0] sz,
                      input logic [31:0] wd, output logic [31:0] rd, output logic rsp);
    int n;
    @(posedge clk);
    #1;
    HSEL = 1'h1;
    HTRANS = 2'h2;
    HADDR = a;
    HWRITE = w;
    HSIZE = sz;
    @(posedge clk);
    #1;
    HSEL = 1'h0;
    HTRANS = 2'h0;
    HWDATA = wd;
    n = 0;
    // the answer is taken at the rising edge where ready is sampled high
    @(posedge clk);
    while (HREADYOUT !== 1'h1 && n < 1000) begin
      n++;
      @(posedge clk);
    end
    rd = HRDATA;
    rsp = HRESP;
  endtask
endmodule

// >>> random_number_source_tb.sv
// Purpose: self-checking bench of the random source
// Assumes: 20 MHz clock, noise bits from a bench shift register
// Notes:   short sample period so the run stays brief
`timescale 1ns/1ps
module random_number_source_tb;
  localparam int PER = 8;
  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        noiseBit = 1'h0;
  logic        noiseOscOn;
  logic        HSEL, HWRITE, HREADYOUT, HRESP, rsp, w, err;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE, sz;
  logic [31:0] HADDR, HWDATA, HRDATA, rdat, a, sel;
  logic [31:0] lfsr = 32'h0C89;
  logic [255:0] hist = '0;
  int          nMismatch = 0;
  int          nTests = 0;
  time         tPrev;

  always #25 clk = ~clk;

  random_number_source #(.PERIOD(PER)) random_number_source_inst (
    .clk(clk), .rst_n(rst_n), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA),
    .noiseBit(noiseBit), .noiseOscOn(noiseOscOn));

  ahb_host_model host_inst (
    .clk(clk), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .HRDATA(HRDATA));

  // ----------------------------------------
  // noise stream and its history
  // ----------------------------------------
  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  always @(posedge clk) hist <= {hist[254:0], noiseBit};
  always @(posedge clk) begin
    #1;
    lfsr = lfsrNext(lfsr);
    noiseBit = lfsr[0];
  end

  // one when the word is a recent 16-bit run of noise with zero upper half
  function automatic logic [31:0] inHist(input logic [31:0] v);
    for (int k = 0; k <= 240; k++) begin
      if (hist[k+:16] === v[15:0] && v[31:16] === 16'h0) return 32'h1;
    end
    return 32'h0;
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      nMismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic testDone;
    $display("comparisons %0d mismatches %0d", nTests, nMismatch);
    if (nMismatch == 0 && nTests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    nMismatch++;
    testDone();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'h1;
    chk("osc", 32'h1, {31'h0, noiseOscOn});
    host_inst.xfer(32'h0, 1'h0, 3'h2, 32'h0, rdat, rsp);
    chk("cfg", 32'h0, rdat);
    host_inst.xfer(32'h4, 1'h0, 3'h2, 32'h0, rdat, rsp);
    chk("stat", 32'h0, rdat);
    $display("test reset done");

    repeat (2 * PER) @(posedge clk);
    host_inst.xfer(32'h4, 1'h0, 3'h2, 32'h0, rdat, rsp);
    chk("ready", 32'h1, rdat);
    for (int i = 0; i < 4; i++) begin
      host_inst.xfer(32'h8, 1'h0, 3'h2, 32'h0, rdat, rsp);
      chk("value", 32'h1, inHist(rdat));
      if (i > 1) chk("gap", 32'(PER), 32'(($time - tPrev) / 50));
      tPrev = $time;
    end
    host_inst.xfer(32'h4, 1'h0, 3'h2, 32'h0, rdat, rsp);
    chk("ready", 32'h0, rdat);
    $display("test stall done");

    host_inst.xfer(32'h0, 1'h1, 3'h2, 32'h4, rdat, rsp);
    host_inst.xfer(32'h0, 1'h0, 3'h2, 32'h0, rdat, rsp);
    chk("cfg", 32'h4, rdat);
    chk("osc", 32'h0, {31'h0, noiseOscOn});
    repeat (3) begin
      repeat (PER) @(posedge clk);
      host_inst.xfer(32'h4, 1'h0, 3'h2, 32'h0, rdat, rsp);
      chk("stat", 32'h0, rdat);
    end
    host_inst.xfer(32'h0, 1'h1, 3'h2, 32'h0, rdat, rsp);
    host_inst.xfer(32'h0, 1'h0, 3'h2, 32'h0, rdat, rsp);
    chk("osc", 32'h1, {31'h0, noiseOscOn});
    $display("test disable done");

    for (int j = 0; j < 4; j++) begin
      a = (j == 2) ? 32'hC : 32'h8;
      host_inst.xfer(a, 1'h0, 3'(j), 32'h0, rdat, rsp);
      chk("resp", 32'h1, {31'h0, rsp});
    end
    for (int i = 0; i < 24; i++) begin
      sel = lfsr;
      a = {28'h0, sel[3:2], 2'h0};
      sz = {1'h0, sel[5:4]};
      w = sel[8];
      err = (sz != 3'h2) || (a == 32'hC);
      host_inst.xfer(a, w, sz, 32'h0, rdat, rsp);
      chk("resp", {31'h0, err}, {31'h0, rsp});
      if (!w && !err && a == 32'h8) chk("value", 32'h1, inHist(rdat));
      if (!w && !err && a == 32'h0) chk("cfg", 32'h0, rdat);
    end
    $display("test access done");
    testDone();
  end
endmodule
